// ---- bench/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import uhr_pkg::*;
  logic       clock          = 1'b0;
  logic       reset_n        = 1'b0;
  uhr_byte_t  rx_in_data     = 8'h00;
  logic       rx_in_valid    = 1'b0;
  logic [3:0] rx_err_in      = 4'h0;
  logic       tx_out_ready   = 1'b0;
  logic [3:0] modem_lines_in = 4'h0;
  logic       rx_timeout     = 1'b0;
  logic       transmitter_idle_flag = 1'b1;
  uhr_addr_t  host_addr;
  logic       host_rd, host_wr, host_interrupt_out, rx_in_ready;
  logic       tx_out_valid, dma_mode;
  uhr_byte_t  host_wdata, host_rdata, tx_out_data, rd_v;
  uhr_byte_t  line_control, modem_control;
  logic [15:0] baud_divisor;
  int         mismatches = 0;
  int         n_compared = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #25 clock = ~clock;
  uhr_host_model u_uhr_host_model (
    .clock, .host_addr, .host_rd, .host_wr, .host_wdata, .host_rdata
  );
  uhr_regif u_uhr_regif (
    .clock, .reset_n, .host_addr, .host_rd, .host_wr, .host_wdata,
    .host_rdata, .host_interrupt_out, .rx_in_data, .rx_in_valid,
    .rx_in_ready, .rx_err_in, .rx_timeout, .tx_out_data,
    .tx_out_valid, .tx_out_ready, .transmitter_idle_flag,
    .modem_lines_in, .baud_divisor, .line_control, .modem_control,
    .dma_mode
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // Read and compare under a mask
  task automatic rdc(input uhr_addr_t a, input uhr_byte_t m,
                     input uhr_byte_t e);
    u_uhr_host_model.rd(a, rd_v);
    chk(rd_v & m, e);
  endtask : rdc
  task automatic wr(input uhr_addr_t a, input uhr_byte_t d);
    u_uhr_host_model.wr(a, d);
  endtask : wr
  // One received byte into the receive stream
  task automatic push(input uhr_byte_t d);
    @(negedge clock);
    rx_in_data  = d;
    rx_in_valid = 1'b1;
    @(negedge clock);
    rx_in_valid = 1'b0;
    rx_in_data  = ~d;
  endtask : push
  task automatic err(input logic [3:0] e);
    @(negedge clock);
    rx_err_in = e;
    @(negedge clock);
    rx_err_in = 4'h0;
  endtask : err
  task automatic summarize;
    $display("Compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    chk(line_control, 8'h03);
    rdc(3'h2, 8'hff, 8'h01);
    rdc(3'h5, 8'h60, 8'h60);
    transmitter_idle_flag = 1'b0;
    rdc(3'h5, 8'h60, 8'h20);
    transmitter_idle_flag = 1'b1;
    wr(3'h7, 8'ha5);
    rdc(3'h7, 8'hff, 8'ha5);
    wr(3'h4, 8'hff);
    rdc(3'h4, 8'hff, 8'h1f);
    wr(3'h1, 8'hff);
    rdc(3'h1, 8'hff, 8'h0f);
    chk(host_interrupt_out, 1'b1);
    rdc(3'h2, 8'hff, 8'h02);
    wr(3'h1, 8'h00);
    // Divisor bank
    wr(3'h3, 8'h80);
    chk(line_control, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    chk(baud_divisor, 16'h1234);
    rdc(3'h0, 8'hff, 8'h34);
    rdc(3'h1, 8'hff, 8'h12);
    wr(3'h3, 8'h03);
    // Errors still flagged with enables off
    err(4'h2);
    chk(host_interrupt_out, 1'b0);
    rdc(3'h5, 8'h1e, 8'h04);
    // Transmit path filled past full while stalled, then drained
    wr(3'h2, 8'h09);
    chk(dma_mode, 1'b1);
    rdc(3'h2, 8'hc0, 8'hc0);
    for (int i = 0; i < 17; i++) begin
      wr(3'h0, uhr_byte_t'(8'h40 + i));
    end
    rdc(3'h5, 8'h20, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(negedge clock);
      chk(tx_out_data, uhr_byte_t'(8'h40 + i));
      tx_out_ready = 1'b1;
      @(negedge clock);
      tx_out_ready = 1'b0;
    end
    @(negedge clock);
    chk(tx_out_valid, 1'b0);
    // Drained FIFO re-arms the transmit-empty interrupt
    wr(3'h1, 8'h02);
    repeat (2) @(negedge clock);
    chk(host_interrupt_out, 1'b1);
    rdc(3'h2, 8'hff, 8'hc2);
    chk(host_interrupt_out, 1'b0);
    wr(3'h1, 8'h00);
    // Receive path filled to full, priority, then drained
    for (int i = 0; i < 16; i++) begin
      push(uhr_byte_t'(8'h80 + i));
    end
    chk(rx_in_ready, 1'b0);
    rdc(3'h5, 8'h01, 8'h01);
    wr(3'h1, 8'h05);
    repeat (2) @(negedge clock);
    chk(host_interrupt_out, 1'b1);
    rdc(3'h2, 8'hff, 8'hc4);
    err(4'h1);
    rdc(3'h2, 8'hff, 8'hc6);
    rdc(3'h5, 8'h1e, 8'h02);
    rdc(3'h2, 8'hff, 8'hc4);
    for (int i = 0; i < 16; i++) begin
      rdc(3'h0, 8'hff, uhr_byte_t'(8'h80 + i));
    end
    rdc(3'h5, 8'h01, 8'h00);
    repeat (2) @(negedge clock);
    chk(host_interrupt_out, 1'b0);
    // Receive flush through fifo control
    push(8'h11);
    push(8'h22);
    // Below the trigger level only the character timeout is pending
    wr(3'h2, 8'h41);
    rx_timeout = 1'b1;
    rdc(3'h2, 8'hff, 8'hcc);
    rx_timeout = 1'b0;
    wr(3'h2, 8'h03);
    rdc(3'h5, 8'h01, 8'h00);
    // Modem line change and its delta
    wr(3'h1, 8'h08);
    @(negedge clock);
    modem_lines_in = 4'h1;
    repeat (10) @(negedge clock);
    chk(host_interrupt_out, 1'b1);
    rdc(3'h6, 8'hff, 8'h11);
    repeat (2) @(negedge clock);
    chk(host_interrupt_out, 1'b0);
    rdc(3'h6, 8'hff, 8'h10);
    // Carrier change and ring rise, then ring trailing edge
    modem_lines_in = 4'hd;
    repeat (10) @(negedge clock);
    rdc(3'h6, 8'hff, 8'hd8);
    modem_lines_in = 4'h9;
    repeat (10) @(negedge clock);
    chk(host_interrupt_out, 1'b1);
    rdc(3'h6, 8'hff, 8'h94);
    wr(3'h1, 8'h00);
    summarize();
  end
endmodule : testbench

// ---- bench/uhr_host_model.sv ----
module uhr_host_model (
  input  wire logic               clock,
  output uhr_pkg::uhr_addr_t      host_addr,
  output logic                    host_rd,
  output logic                    host_wr,
  output uhr_pkg::uhr_byte_t      host_wdata,
  input  wire uhr_pkg::uhr_byte_t host_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import uhr_pkg::*;
  // Idle bus at time zero
  initial begin
    host_addr  = 3'h0;
    host_rd    = 1'b0;
    host_wr    = 1'b0;
    host_wdata = 8'h00;
  end
  // One write, strobe high over one edge; released lines show inverse
  task automatic wr(input uhr_addr_t a, input uhr_byte_t d);
    @(negedge clock);
    host_addr  = a;
    host_wdata = d;
    host_wr    = 1'b1;
    @(negedge clock);
    host_wr    = 1'b0;
    host_addr  = ~a;
    host_wdata = ~d;
  endtask : wr
  // One read, data taken a cycle after the strobe drops
  task automatic rd(input uhr_addr_t a, output uhr_byte_t d);
    @(negedge clock);
    host_addr = a;
    host_rd   = 1'b1;
    @(negedge clock);
    host_rd   = 1'b0;
    host_addr = ~a;
    @(negedge clock);
    d = host_rdata;
  endtask : rd
endmodule : uhr_host_model

// ---- bench/uhr_regif_monitor.sv ----
module uhr_regif_monitor (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire uhr_pkg::uhr_addr_t host_addr,
  input wire logic               host_rd,
  input wire logic               host_wr,
  input wire uhr_pkg::uhr_byte_t host_wdata,
  input wire uhr_pkg::uhr_byte_t host_rdata,
  input wire logic               host_interrupt_out,
  input wire logic [3:0]         rx_err_in,
  input wire uhr_pkg::uhr_byte_t tx_out_data,
  input wire logic               tx_out_valid,
  input wire logic               tx_out_ready,
  input wire logic [3:0]         modem_lines_in,
  input wire logic [15:0]        baud_divisor,
  input wire uhr_pkg::uhr_byte_t line_control,
  input wire uhr_pkg::uhr_byte_t modem_control,
  input wire logic               dma_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  import uhr_pkg::*;
  logic [3:0] ien_q;
  uhr_byte_t  scr_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // Mirror of the enable bits, banked behind the divisor select
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ien_q <= 4'h0;
    end else if (host_wr && host_addr == 3'h1 && !line_control[7]) begin
      ien_q <= host_wdata[3:0];
    end
  end
  // Mirror of the scratch byte
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      scr_q <= 8'h00;
    end else if (host_wr && host_addr == 3'h7) begin
      scr_q <= host_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_div_low_load : assert property (
    host_wr && host_addr == 3'h0 && line_control[7]
    |=> baud_divisor[7:0] == $past(host_wdata))
    else $error("divisor low byte not loaded");
  a_line_ctl_load : assert property (
    host_wr && host_addr == 3'h3 |=> line_control == $past(host_wdata))
    else $error("line control not loaded");
  a_modem_ctl_load : assert property (
    host_wr && host_addr == 3'h4
    |=> modem_control == {3'h0, $past(host_wdata[4:0])})
    else $error("modem control not loaded");
  a_dma_mode_load : assert property (
    host_wr && host_addr == 3'h2 && host_wdata[0]
    |=> dma_mode == $past(host_wdata[3]))
    else $error("dma mode not loaded");
  a_tx_stall_hold : assert property (
    tx_out_valid && !tx_out_ready && !host_wr
    |=> tx_out_valid && $stable(tx_out_data))
    else $error("stalled transmit word changed");
  a_scratch_echo : assert property (
    $rose(host_rd) && host_addr == 3'h7
    |-> ##2 host_rdata == $past(scr_q, 2))
    else $error("scratch read wrong");
  a_all_off_quiet : assert property (
    (ien_q == 4'h0) [*2] |-> !host_interrupt_out)
    else $error("interrupt with all enables off");
  a_line_err_irq : assert property (
    ien_q[2] && rx_err_in != 4'h0 |-> ##[1:4] host_interrupt_out)
    else $error("no interrupt on line error");
  a_modem_irq : assert property (
    ien_q[3] && ($changed(modem_lines_in & 4'hb)
                 || $fell(modem_lines_in[2]))
    |-> ##[3:10] host_interrupt_out)
    else $error("no interrupt on modem change");
  c_tx_stall : cover property (tx_out_valid && !tx_out_ready);
  c_line_err : cover property (ien_q[2] && rx_err_in != 4'h0);
  c_irq_seen : cover property ($rose(host_interrupt_out));
endmodule : uhr_regif_monitor

bind uhr_regif uhr_regif_monitor u_uhr_regif_monitor (
  .clock, .reset_n, .host_addr, .host_rd, .host_wr, .host_wdata,
  .host_rdata, .host_interrupt_out, .rx_err_in, .tx_out_data,
  .tx_out_valid, .tx_out_ready, .modem_lines_in, .baud_divisor,
  .line_control, .modem_control, .dma_mode
);

// ---- design/uhr_fifo.sv ----
`include "uhr_regs.svh"
// Synchronous FIFO with valid/ready on both sides
module uhr_fifo #(
  parameter int WIDTH = `UHR_DWIDTH,
  parameter int DEPTH = `UHR_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock) begin
    if (!reset_n || flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule : uhr_fifo

// ---- design/uhr_pkg.sv ----
package uhr_pkg;
  typedef logic [7:0] uhr_byte_t;
  typedef logic [2:0] uhr_addr_t;
endpackage : uhr_pkg

// ---- design/uhr_regif.sv ----
`include "uhr_regs.svh"
// Contract
// - Interrupt enable register gates five interrupt types onto host interrupt.
// - Writing 1 enables a source, writing 0 disables it.
// - Disabled source is neither identified nor raises the host interrupt.
// - All enables zero: no identification bits, host interrupt inactive.
// - Line and modem status update regardless of enables.
// - Modem status enable: interrupt while any modem delta flag set.
// - Line status enable: interrupt when line error bits 1-4 change.
// - Transmit empty enable: interrupt while transmit buffer empty flag set, until an ident read shows it.
// - Address 0, divisor access 0: write transmit, read receive buffer.
// - Divisor access 1: addresses 0 and 1 reach divisor bytes.
// - Address 2 read gives FIFO enabled, zeros, identifier, pending-low.
// - Address 2 write loads trigger, DMA, FIFO resets, FIFO enable.
// - Address 3 holds line control with divisor access in bit 7.
// - Address 5 reports line status bits as laid out.
// - Address 6 reports modem lines high nibble, deltas low nibble.
// - Sixteen-byte receive and transmit FIFOs behind the buffer address.
// - Priority: line status, receive data/timeout, transmit empty, modem.
module uhr_regif
  import uhr_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire uhr_pkg::uhr_addr_t host_addr,
  input  wire logic          host_rd,
  input  wire logic          host_wr,
  input  wire uhr_pkg::uhr_byte_t host_wdata,
  output uhr_pkg::uhr_byte_t host_rdata,
  output logic               host_interrupt_out,
  input  wire uhr_pkg::uhr_byte_t rx_in_data,
  input  wire logic          rx_in_valid,
  output logic               rx_in_ready,
  input  wire logic [3:0]    rx_err_in,
  input  wire logic          rx_timeout,
  output uhr_pkg::uhr_byte_t tx_out_data,
  output logic               tx_out_valid,
  input  wire logic          tx_out_ready,
  input  wire logic          transmitter_idle_flag,
  input  wire logic [3:0]    modem_lines_in,
  output logic [15:0]        baud_divisor,
  output uhr_pkg::uhr_byte_t line_control,
  output uhr_pkg::uhr_byte_t modem_control,
  output logic               dma_mode
);
  import uhr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decodes
  uhr_byte_t  interrupt_enable_q;
  uhr_byte_t  scratch_store_q;
  uhr_byte_t  dl_low_q;
  uhr_byte_t  dl_high_q;
  uhr_byte_t  line_control_q;
  logic [4:0] modem_control_q;
  logic [1:0] trig_sel_q;
  logic       fifo_en_q;
  logic       dma_q;
  logic [3:0] lerr_q;
  logic       lerr_chg_q;
  logic [3:0] mdelta_q;
  logic [3:0] mline_s1_q;
  logic [3:0] mline_s2_q;
  logic [3:0] mline_s3_q;
  logic [3:0] mline_q;
  uhr_byte_t  rdata_q;
  logic [2:0] iid_q;
  logic       pend_q;
  logic       rd_q;
  logic       divisor_access_select;
  logic       wr_data;
  logic       rd_data;
  logic       wr_fcr;
  logic       rd_iir;
  logic       rd_lsr;
  logic       rd_msr;
  logic       tx_in_ready;
  logic       rx_valid;
  uhr_byte_t  rx_data;
  logic [4:0] rx_count;
  logic [4:0] tx_count;
  logic       tx_buffer_empty_flag_pend_q;
  logic       tx_empty;
  logic       ls_int;
  logic       rx_int;
  logic       to_int;
  logic       tx_int;
  logic       ms_int;
  logic       rx_flush;
  logic       tx_flush;
  logic [4:0] trig_lvl;
  uhr_byte_t  lsr_val;
  uhr_byte_t  msr_val;
  uhr_byte_t  iir_val;
  logic [2:0] iid_d;
  logic       pend_d;
  logic [3:0] lerr_base;
  logic [3:0] mdelta_new;
  logic       tx_last_pop;

  // Address match for a given offset
  function automatic logic hit(input uhr_addr_t a, input uhr_addr_t off);
    hit = (a == off);
  endfunction : hit

  assign divisor_access_select    = line_control_q[`UHR_LC_DIVISOR_ACCESS_SELECT];
  assign wr_data = host_wr && hit(host_addr, `UHR_A_DATA) && !divisor_access_select;
  assign rd_data = host_rd && !rd_q && hit(host_addr, `UHR_A_DATA)
                   && !divisor_access_select;
  assign wr_fcr  = host_wr && hit(host_addr, `UHR_A_IIDFC);
  assign rd_iir  = host_rd && !rd_q && hit(host_addr, `UHR_A_IIDFC);
  assign rd_lsr  = host_rd && !rd_q && hit(host_addr, `UHR_A_LSTAT);
  assign rd_msr  = host_rd && !rd_q && hit(host_addr, `UHR_A_MSTAT);

  // Read strobe edge tracker
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= host_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs
  // FIFO resets act only with enable bit set; clearing enable empties both
  assign rx_flush = wr_fcr && (!host_wdata[`UHR_FC_EN]
                    || host_wdata[`UHR_FC_RXRST]);
  assign tx_flush = wr_fcr && (!host_wdata[`UHR_FC_EN]
                    || host_wdata[`UHR_FC_TXRST]);

  uhr_fifo #(.WIDTH(`UHR_DWIDTH), .DEPTH(`UHR_DEPTH)) u_rx_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .flush     (rx_flush),
    .in_data   (rx_in_data),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rd_data),
    .count     (rx_count)
  );

  // A write that finds the transmit FIFO full is dropped without trace, so
  // the host paces itself on the transmit buffer empty flag
  uhr_fifo #(.WIDTH(`UHR_DWIDTH), .DEPTH(`UHR_DEPTH)) u_tx_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .flush     (tx_flush),
    .in_data   (host_wdata),
    .in_valid  (wr_data),
    .in_ready  (tx_in_ready),
    .out_data  (tx_out_data),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready),
    .count     (tx_count)
  );

  assign tx_empty = (tx_count == 5'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Host-written registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      interrupt_enable_q <= `UHR_RST_BYTE;
      dl_low_q           <= `UHR_RST_BYTE;
      dl_high_q          <= `UHR_RST_BYTE;
      line_control_q     <= `UHR_RST_LCTL;
      modem_control_q    <= 5'h00;
      scratch_store_q    <= `UHR_RST_BYTE;
    end else if (host_wr) begin
      if (hit(host_addr, `UHR_A_DATA) && divisor_access_select) begin
        dl_low_q <= host_wdata;
      end else if (hit(host_addr, `UHR_A_IEN) && divisor_access_select) begin
        dl_high_q <= host_wdata;
      end else if (hit(host_addr, `UHR_A_IEN)) begin
        interrupt_enable_q <= {4'h0, host_wdata[3:0]};
      end else if (hit(host_addr, `UHR_A_LCTL)) begin
        line_control_q <= host_wdata;
      end else if (hit(host_addr, `UHR_A_MCTL)) begin
        modem_control_q <= host_wdata[4:0];
      end else if (hit(host_addr, `UHR_A_SCR)) begin
        scratch_store_q <= host_wdata;
      end
    end
  end

  // FIFO control fields
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fifo_en_q  <= 1'b0;
      dma_q      <= 1'b0;
      trig_sel_q <= 2'h0;
    end else if (wr_fcr) begin
      fifo_en_q <= host_wdata[`UHR_FC_EN];
      if (host_wdata[`UHR_FC_EN]) begin
        dma_q      <= host_wdata[`UHR_FC_DMA];
        trig_sel_q <= host_wdata[7:6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status capture, independent of enables
  // Modem line synchroniser, three stages
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mline_s1_q <= 4'h0;
      mline_s2_q <= 4'h0;
      mline_s3_q <= 4'h0;
      mline_q    <= 4'h0;
    end else begin
      mline_s1_q <= modem_lines_in;
      mline_s2_q <= mline_s1_q;
      mline_s3_q <= mline_s2_q;
      if (mline_s2_q == mline_s3_q) begin
        mline_q <= mline_s3_q;
      end
    end
  end

  // New deltas, judged on the same settled word that updates the lines, so
  // a flag never rises before the status bits show the change
  always_comb begin
    mdelta_new = 4'h0;
    if (mline_s2_q == mline_s3_q) begin
      mdelta_new = mline_q ^ mline_s3_q;
      // Ring counts only its trailing edge
      mdelta_new[`UHR_MS_RING] = mline_q[`UHR_MS_RING]
                                 & !mline_s3_q[`UHR_MS_RING];
    end
  end

  // Modem deltas: set wins over read clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mdelta_q <= 4'h0;
    end else begin
      mdelta_q <= (rd_msr ? 4'h0 : mdelta_q) | mdelta_new;
    end
  end

  // Error flags that survive a status read in this cycle; an error arriving
  // with the read is kept and raises the change flag again, set wins
  assign lerr_base = rd_lsr ? 4'h0 : lerr_q;

  // Line error flags, cleared by reading line status; change flag for irq
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lerr_q     <= 4'h0;
      lerr_chg_q <= 1'b0;
    end else begin
      lerr_q     <= lerr_base | rx_err_in;
      lerr_chg_q <= (rd_lsr ? 1'b0 : lerr_chg_q)
                    | ((lerr_base | rx_err_in) != lerr_base);
    end
  end

  // Last word leaves the transmit FIFO
  assign tx_last_pop = tx_out_valid && tx_out_ready
                       && (tx_count == `UHR_CNT_LAST);

  // Transmit-empty interrupt latch: armed whenever the FIFO runs dry, by a
  // drain or a flush, and that set wins over an ident read in the same
  // cycle; a transmit write or a read of the ident showing it disarms it
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tx_buffer_empty_flag_pend_q <= 1'b1;
    end else if (wr_data) begin
      tx_buffer_empty_flag_pend_q <= 1'b0;
    end else if (tx_last_pop || (tx_flush && !tx_empty)) begin
      tx_buffer_empty_flag_pend_q <= 1'b1;
    end else if (rd_iir && iid_q == `UHR_ID_TX && !pend_q) begin
      tx_buffer_empty_flag_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt sources gated by enables
  // Receive trigger level, in bytes, chosen by the two select bits
  always_comb begin
    case (trig_sel_q)
      2'h0:    trig_lvl = `UHR_TRIG0;
      2'h1:    trig_lvl = `UHR_TRIG1;
      2'h2:    trig_lvl = `UHR_TRIG2;
      default: trig_lvl = `UHR_TRIG3;
    endcase
  end

  assign ls_int = interrupt_enable_q[`UHR_IE_LS] && lerr_chg_q;
  assign rx_int = interrupt_enable_q[`UHR_IE_RX] &&
                  (fifo_en_q ? (rx_count >= trig_lvl) : rx_valid);
  assign to_int = interrupt_enable_q[`UHR_IE_RX] && fifo_en_q &&
                  rx_timeout && rx_valid;
  assign tx_int = interrupt_enable_q[`UHR_IE_TX] && tx_empty
                  && tx_buffer_empty_flag_pend_q;
  assign ms_int = interrupt_enable_q[`UHR_IE_MS] && (mdelta_q != 4'h0);

  // Priority encoder of pending identification
  always_comb begin
    pend_d = 1'b1;
    iid_d  = `UHR_ID_NONE;
    if (ls_int) begin
      pend_d = 1'b0;
      iid_d  = `UHR_ID_LS;
    end else if (rx_int) begin
      pend_d = 1'b0;
      iid_d  = `UHR_ID_RX;
    end else if (to_int) begin
      pend_d = 1'b0;
      iid_d  = `UHR_ID_TO;
    end else if (tx_int) begin
      pend_d = 1'b0;
      iid_d  = `UHR_ID_TX;
    end else if (ms_int) begin
      pend_d = 1'b0;
      iid_d  = `UHR_ID_MS;
    end
  end

  // Identification frozen while the host holds a read of it
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      iid_q  <= `UHR_ID_NONE;
      pend_q <= 1'b1;
    end else if (!(host_rd && hit(host_addr, `UHR_A_IIDFC))) begin
      iid_q  <= iid_d;
      pend_q <= pend_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and outputs
  assign lsr_val = {fifo_en_q && (lerr_q != 4'h0),
                    tx_empty && transmitter_idle_flag,
                    tx_empty, lerr_q, rx_valid};
  assign msr_val = {mline_q, mdelta_q};
  assign iir_val = {fifo_en_q, fifo_en_q, 2'h0,
                    iid_q, pend_q};

  // Read data, taken once per read on the strobe's rising edge, so a long
  // strobe never picks up the word behind the one just popped
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_q <= `UHR_RST_BYTE;
    end else if (host_rd && !rd_q) begin
      if (hit(host_addr, `UHR_A_DATA)) begin
        rdata_q <= divisor_access_select ? dl_low_q : rx_data;
      end else if (hit(host_addr, `UHR_A_IEN)) begin
        rdata_q <= divisor_access_select ? dl_high_q : interrupt_enable_q;
      end else if (hit(host_addr, `UHR_A_IIDFC)) begin
        rdata_q <= iir_val;
      end else if (hit(host_addr, `UHR_A_LCTL)) begin
        rdata_q <= line_control_q;
      end else if (hit(host_addr, `UHR_A_MCTL)) begin
        rdata_q <= {3'h0, modem_control_q};
      end else if (hit(host_addr, `UHR_A_LSTAT)) begin
        rdata_q <= lsr_val;
      end else if (hit(host_addr, `UHR_A_MSTAT)) begin
        rdata_q <= msr_val;
      end else begin
        rdata_q <= scratch_store_q;
      end
    end
  end

  // Outputs; the interrupt pin follows the registered pending bit, so it
  // cannot glitch while several sources change in one cycle
  assign host_rdata         = rdata_q;
  assign host_interrupt_out = !pend_q;
  assign baud_divisor       = {dl_high_q, dl_low_q};
  assign line_control       = line_control_q;
  assign modem_control      = {3'h0, modem_control_q};
  assign dma_mode           = fifo_en_q && dma_q;
endmodule : uhr_regif

// ---- design/uhr_regs.svh ----
`ifndef UHR_REGS_SVH
`define UHR_REGS_SVH
// Register offsets
`define UHR_A_DATA   3'h0
`define UHR_A_IEN    3'h1
`define UHR_A_IIDFC  3'h2
`define UHR_A_LCTL   3'h3
`define UHR_A_MCTL   3'h4
`define UHR_A_LSTAT  3'h5
`define UHR_A_MSTAT  3'h6
`define UHR_A_SCR    3'h7
// Field positions
`define UHR_IE_RX    0
`define UHR_IE_TX    1
`define UHR_IE_LS    2
`define UHR_IE_MS    3
`define UHR_LC_DIVISOR_ACCESS_SELECT  7
`define UHR_FC_EN    0
`define UHR_FC_RXRST 1
`define UHR_FC_TXRST 2
`define UHR_FC_DMA   3
`define UHR_MS_RING  2
// Identification codes
`define UHR_ID_NONE  3'h0
`define UHR_ID_LS    3'h3
`define UHR_ID_RX    3'h2
`define UHR_ID_TO    3'h6
`define UHR_ID_TX    3'h1
`define UHR_ID_MS    3'h0
// Reset values
`define UHR_RST_BYTE 8'h00
`define UHR_RST_LCTL 8'h03
// Trigger levels, last-word count, FIFO depth and width
`define UHR_TRIG0    5'h01
`define UHR_TRIG1    5'h04
`define UHR_TRIG2    5'h08
`define UHR_TRIG3    5'h0e
`define UHR_CNT_LAST 5'h01
`define UHR_DEPTH    16
`define UHR_DWIDTH   8
`endif
